// ==== trps_map.svh ====
// timing and encoding constants of the three rail power sequencer
`ifndef TRPS_MAP_SVH
`define TRPS_MAP_SVH

`define TRPS_CLK_PERIOD_NS     5
`define TRPS_TICK_RATIO_US_NF  120
`define TRPS_FIRST_DELAY_TICKS 4'h9
`define TRPS_STEP_DELAY_TICKS  4'h8
`define TRPS_CNT_ZERO          4'h0
`define TRPS_CNT_ONE           4'h1
`define TRPS_RAILS_NONE        3'h0
`define TRPS_RAIL1_MASK        3'h1
`define TRPS_RAIL12_MASK       3'h3
`define TRPS_RAILS_ALL         3'h7
`define TRPS_POL_MASK          3'h7
`define TRPS_RAIL_COUNT        3
`define TRPS_OE_HOLD           1'b1
`define TRPS_DATA_LOW          1'b0

`endif

// ==== trps_pkg.sv ====
// types of the three rail power sequencer
package trps_pkg;
   typedef enum logic [2:0] {
      TRPS_IDLE  = 3'b000,
      TRPS_WAIT1 = 3'b001,
      TRPS_WAIT2 = 3'b010,
      TRPS_WAIT3 = 3'b011,
      TRPS_ON    = 3'b100,
      TRPS_DOWN  = 3'b101
   } trps_state_t;

   typedef struct packed {
      logic       enable;
      logic       polarity;
   } trps_inputs_t;
endpackage

// ==== trps_sequencer.sv ====
// three rail power sequencer core
//
// What this block does
// - counts ticks of the sequencing clock
// - outputs driven low in reset and two clocks after, then inactive until enable seen
// - release outputs one, two, three in order
// - output one after nine to ten ticks
// - output two eight ticks after one
// - output three eight ticks after two
// - enable loss: output three off after nine
// - then two, then one, eight ticks apart
// - polarity high inverts all three outputs
// - polarity low gives active high outputs
// - early enable loss resets counter, releases nothing
// - later enable loss forces controlled shutdown
`timescale 1ns/10ps
`default_nettype none
`include "trps_map.svh"

module trps_sequencer
   import trps_pkg::*;
(
   input  wire logic i_clk,
   input  wire logic i_reset,
   input  wire logic i_enable,
   input  wire logic i_output_polarity_select,
   output var  logic o_sequence_output_1,
   output var  logic o_sequence_output_2,
   output var  logic o_sequence_output_3,
   output var  logic o_sequence_output_1_oe,
   output var  logic o_sequence_output_2_oe,
   output var  logic o_sequence_output_3_oe
);

   // ----------------------------------------
   // declarations
   // ----------------------------------------
   trps_inputs_t meta_reg;
   trps_inputs_t sync_reg;

   trps_state_t  state_reg;
   trps_state_t  state_next;

   logic [3:0]   cnt_reg;
   logic [3:0]   cnt_next;

   logic [2:0]   rails_reg;
   logic [2:0]   rails_next;

   logic [2:0]   oe_reg;
   logic [2:0]   dat_reg;

   logic         en;
   logic         pol;
   logic         tick_last;
   logic         shed_last;

   // ----------------------------------------
   // input synchroniser, first stage
   // ----------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         meta_reg <= '0;
      end else begin
         meta_reg <= '{enable: i_enable, polarity: i_output_polarity_select};
      end
   end

   // ----------------------------------------
   // input synchroniser, second stage
   // ----------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         sync_reg <= '0;
      end else begin
         sync_reg <= meta_reg;
      end
   end

   // ----------------------------------------
   // decoded conditions
   // ----------------------------------------
   assign en        = sync_reg.enable;
   assign pol       = sync_reg.polarity;
   assign tick_last = (cnt_reg == `TRPS_CNT_ONE);
   assign shed_last = ((rails_reg >> 1) == `TRPS_RAILS_NONE);

   // ----------------------------------------
   // state register
   // ----------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         state_reg <= TRPS_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         TRPS_IDLE: begin
            if (en) begin
               state_next = TRPS_WAIT1;
            end
         end

         TRPS_WAIT1: begin
            if (!en) begin
               state_next = TRPS_IDLE;
            end else if (tick_last) begin
               state_next = TRPS_WAIT2;
            end
         end

         TRPS_WAIT2: begin
            if (!en) begin
               state_next = TRPS_DOWN;
            end else if (tick_last) begin
               state_next = TRPS_WAIT3;
            end
         end

         TRPS_WAIT3: begin
            if (!en) begin
               state_next = TRPS_DOWN;
            end else if (tick_last) begin
               state_next = TRPS_ON;
            end
         end

         TRPS_ON: begin
            if (!en) begin
               state_next = TRPS_DOWN;
            end
         end

         TRPS_DOWN: begin
            if (tick_last && shed_last) begin
               state_next = TRPS_IDLE;
            end
         end

         default: begin
            state_next = TRPS_IDLE;
         end
      endcase
   end

   // ----------------------------------------
   // tick counter register
   // ----------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         cnt_reg <= `TRPS_FIRST_DELAY_TICKS;
      end else begin
         cnt_reg <= cnt_next;
      end
   end

   // ----------------------------------------
   // tick counter next value
   // ----------------------------------------
   always_comb begin
      cnt_next = cnt_reg - `TRPS_CNT_ONE;
      unique case (state_reg)
         TRPS_IDLE: begin
            cnt_next = `TRPS_FIRST_DELAY_TICKS;
         end

         TRPS_WAIT1: begin
            if (!en) begin
               cnt_next = `TRPS_FIRST_DELAY_TICKS;
            end else if (tick_last) begin
               cnt_next = `TRPS_STEP_DELAY_TICKS;
            end
         end

         TRPS_WAIT2: begin
            if (!en) begin
               cnt_next = `TRPS_FIRST_DELAY_TICKS;
            end else if (tick_last) begin
               cnt_next = `TRPS_STEP_DELAY_TICKS;
            end
         end

         TRPS_WAIT3: begin
            if (!en) begin
               cnt_next = `TRPS_FIRST_DELAY_TICKS;
            end
         end

         TRPS_ON: begin
            cnt_next = `TRPS_FIRST_DELAY_TICKS;
         end

         TRPS_DOWN: begin
            if (tick_last && shed_last) begin
               cnt_next = `TRPS_FIRST_DELAY_TICKS;
            end else if (tick_last) begin
               cnt_next = `TRPS_STEP_DELAY_TICKS;
            end
         end

         default: begin
            cnt_next = `TRPS_FIRST_DELAY_TICKS;
         end
      endcase
   end

   // ----------------------------------------
   // rail mask register
   // ----------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         rails_reg <= `TRPS_RAILS_NONE;
      end else begin
         rails_reg <= rails_next;
      end
   end

   // ----------------------------------------
   // rail mask next value
   // ----------------------------------------
   always_comb begin
      rails_next = rails_reg;
      unique case (state_reg)
         TRPS_IDLE: begin
            rails_next = `TRPS_RAILS_NONE;
         end

         TRPS_WAIT1: begin
            if (en && tick_last) begin
               rails_next = `TRPS_RAIL1_MASK;
            end
         end

         TRPS_WAIT2: begin
            if (en && tick_last) begin
               rails_next = `TRPS_RAIL12_MASK;
            end
         end

         TRPS_WAIT3: begin
            if (en && tick_last) begin
               rails_next = `TRPS_RAILS_ALL;
            end
         end

         TRPS_ON: begin
            rails_next = `TRPS_RAILS_ALL;
         end

         TRPS_DOWN: begin
            if (tick_last) begin
               rails_next = rails_reg >> 1;
            end
         end

         default: begin
            rails_next = `TRPS_RAILS_NONE;
         end
      endcase
   end

   // ----------------------------------------
   // open drain outputs with polarity, per rail
   // ----------------------------------------
   generate
      for (genvar g = 0; g < `TRPS_RAIL_COUNT; g++) begin : g_rail
         logic level_next;

         assign level_next = rails_next[g] ^ pol;

         always_ff @(posedge i_clk) begin
            if (i_reset) begin
               oe_reg[g] <= `TRPS_OE_HOLD;
            end else begin
               oe_reg[g] <= ~level_next;
            end
         end

         always_ff @(posedge i_clk) begin
            if (i_reset) begin
               dat_reg[g] <= `TRPS_DATA_LOW;
            end else begin
               dat_reg[g] <= `TRPS_DATA_LOW;
            end
         end
      end
   endgenerate

   // ----------------------------------------
   // pins
   // ----------------------------------------
   assign o_sequence_output_1    = dat_reg[0];
   assign o_sequence_output_2    = dat_reg[1];
   assign o_sequence_output_3    = dat_reg[2];
   assign o_sequence_output_1_oe = oe_reg[0];
   assign o_sequence_output_2_oe = oe_reg[1];
   assign o_sequence_output_3_oe = oe_reg[2];

endmodule

`default_nettype wire

// ==== trps_reg_model.sv ====
// regulator enable pins seen through pull-ups
`timescale 1ns/10ps
`default_nettype none
module trps_reg_model (
   input  wire logic [2:0] i_oe,
   output var  logic [2:0] o_pin
);
   // pull-up wins wherever no pin is pulled low
   assign o_pin = ~i_oe;
endmodule
`default_nettype wire

// ==== trps_sequencer_chk.sv ====
// sequencer checker
`timescale 1ns/10ps
`default_nettype none
module trps_sequencer_chk (
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_enable,
   input wire logic i_output_polarity_select,
   input wire logic o_sequence_output_1_oe,
   input wire logic o_sequence_output_2_oe,
   input wire logic o_sequence_output_3_oe
);
   wire logic [2:0] oe = {o_sequence_output_3_oe, o_sequence_output_2_oe, o_sequence_output_1_oe};
   wire logic       p  = i_output_polarity_select;
   wire logic       e  = i_enable;
   logic [4:0]      quiet_cnt;
   logic            e_d;
   always_ff @(posedge i_clk) begin
      e_d <= e;
      if (i_reset || e != e_d) quiet_cnt <= 5'h0;
      else if (quiet_cnt != 5'h1f) quiet_cnt <= quiet_cnt + 5'h1;
   end
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_reset);
   sequence s_h; (e && !p)[*8]; endsequence
   sequence s_l; (!e && !p)[*8]; endsequence
   property p_idle; (!e && !p && oe == 3'h7)[*3] |=> oe == 3'h7; endproperty
   a_idle: assert property (p_idle) else $error("idle");
   property p_up; $rose(e) && oe == 3'h7 ##1 s_h ##1 (e && !p)[*4] |-> ##[0:2] $fell(oe[0]); endproperty
   a_up: assert property (p_up) else $error("up");
   property p_two; $fell(oe[0]) && oe[1] ##1 s_h |-> $fell(oe[1]); endproperty
   a_two: assert property (p_two) else $error("two");
   property p_three; $fell(oe[1]) && oe[2] ##1 s_h |-> $fell(oe[2]); endproperty
   a_three: assert property (p_three) else $error("three");
   property p_off; $fell(e) && oe == 3'h0 ##1 s_l ##1 (!e && !p)[*4] |-> ##[0:2] $rose(oe[2]); endproperty
   a_off: assert property (p_off) else $error("off");
   property p_down; $rose(oe[2]) && !oe[1] ##1 s_l |-> $rose(oe[1]); endproperty
   a_down: assert property (p_down) else $error("down");
   property p_shed; $fell(e) && oe == 3'h4 ##2 oe == 3'h4 && !e && !p ##1 s_l ##1 (!e && !p)[*2]
      |-> ##[0:2] $rose(oe[1]) && oe[2]; endproperty
   a_shed: assert property (p_shed) else $error("shed");
   property p_pol; $changed(p) && quiet_cnt == 5'h1f ##1 ($stable(p) && $stable(e))[*4] |-> oe == ~$past(oe, 4);
   endproperty
   a_pol: assert property (p_pol) else $error("pol");
   c_up: cover property ($fell(oe[2]));
   c_dn: cover property ($rose(oe[0]));
   c_pol: cover property ($changed(p));
endmodule
bind trps_sequencer trps_sequencer_chk i_chk (.i_clk(i_clk), .i_reset(i_reset), .i_enable(i_enable),
   .i_output_polarity_select(i_output_polarity_select), .o_sequence_output_1_oe(o_sequence_output_1_oe),
   .o_sequence_output_2_oe(o_sequence_output_2_oe), .o_sequence_output_3_oe(o_sequence_output_3_oe));
`default_nettype wire

// ==== tb_trps_sequencer.sv ====
// sequencer bench
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin error_cnt++; $display("BAD %0t %h %h", $time, a, b); end end
module tb_trps_sequencer import trps_pkg::*;;
   logic         i_clk = 1'h0, i_reset = 1'h1;
   trps_inputs_t x = '0;
   logic [2:0]   oe, pin, dat;
   int           error_cnt = 0, cmp_count = 0;
   // rows: enable, polarity, cycles, expected pins
   logic [10:0]  rows [9] = '{11'h450, 11'h439, 11'h443, 11'h447, 11'h628, 11'h42f, 11'h08b, 11'h041, 11'h040};
   trps_sequencer i_dut (.i_clk, .i_reset, .i_enable(x.enable), .i_output_polarity_select(x.polarity),
      .o_sequence_output_1(dat[0]), .o_sequence_output_2(dat[1]), .o_sequence_output_3(dat[2]),
      .o_sequence_output_1_oe(oe[0]), .o_sequence_output_2_oe(oe[1]), .o_sequence_output_3_oe(oe[2]));
   trps_reg_model i_reg (.i_oe(oe), .o_pin(pin));
   always #2.5 i_clk = ~i_clk;
   task automatic step(input logic [10:0] v);
      x = v[10:9];
      repeat (v[8:3]) @(negedge i_clk);
      `CHK(pin, v[2:0])
   endtask
   task automatic summarize;
      $display("errors %0d compares %0d", error_cnt, cmp_count);
      if (error_cnt == 0 && cmp_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      repeat (5) @(negedge i_clk);
      `CHK(pin, 3'h0)
      i_reset = 1'h0;
      foreach (rows[k]) step(rows[k]);
      step(11'h430);
      step(11'h0a0);
      step(11'h4cb);
      step(11'h089);
      step(11'h040);
      x = 2'h2;
      repeat (15) @(negedge i_clk);
      `CHK(pin, 3'h1)
      i_reset = 1'h1;
      repeat (2) @(negedge i_clk);
      `CHK(pin, 3'h0)
      i_reset = 1'h0;
      repeat (11) @(negedge i_clk);
      `CHK(pin, 3'h0)
      @(negedge i_clk);
      `CHK(pin, 3'h1)
      `CHK(dat, 3'h0)
      summarize();
   end
endmodule
`default_nettype wire
